// [design/bws_status_flags.sv]
// Bus and wake status flag bank with clear-on-read and restart behaviour
// How it works
// - Reserved bits of both registers read zero
// - Timeout bit 4 set on timeout, read clears
// - Bit 3 flags selective-wake system error
// - Bits 2:1 encode thermal, TXD, bus dominant
// - Bit 0 flags undervoltage, transmitter disabled
// - Power-on or soft reset zeroes both registers
// - Restart zeroes fault bits 15:7, keeps 6:0
// - Restart keeps wake bits 10:7 and 1
// - Undervoltage detect only in normal/receive-only
// - TXD timeout ends on high, wake-capable, off
// - Bus timeout ends on recessive, wake-capable, off
// - Undervoltage ends when supply above threshold
// - Transmit re-enabled after TXD high enable time
// - Timeout flag set on silence, selective wake only
// - Timeout interrupt in Stop/Normal when mask set
// - System error on config error or overflow
// - System error updated only with selective wake
// - Timeout flag read-proof until interrupt falls
// - Bit 9 set on bus wake, read clears
// - Bits 8,7 set on timer wakes, read clears
// - Bits 4:0 set on pin wakes, read clears
// - Fail-safe entry clears whole wake register
module bws_status_flags
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        restart_evt,
  input  wire logic        failsafe_entry,
  // Register read port
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  output logic [15:0]      reg_rdata,
  // Transceiver state
  input  wire logic        xcvr_normal,
  input  wire logic        xcvr_rx_only,
  input  wire logic        xcvr_wake_capable,
  input  wire logic        xcvr_off,
  input  wire logic        txd_high,
  input  wire logic        bus_recessive,
  input  wire logic        thermal_shutdown,
  input  wire logic        txd_dom_detect,
  input  wire logic        bus_dom_detect,
  input  wire logic        supply_below_thr,
  output logic             tx_enable,
  // Selective wake
  input  wire logic        selective_wake_enable,
  input  wire logic        bus_silence_indication,
  input  wire logic        config_error,
  input  wire logic [5:0]  error_count,
  input  wire logic        mode_stop_or_normal,
  input  wire logic        bus_timeout_irq_mask,
  input  wire logic        interrupt_out_n,
  output logic             bus_timeout_irq,
  // Wake sources
  input  wire logic        bus_wake_evt,
  input  wire logic        timer1_wake_evt,
  input  wire logic        timer2_wake_evt,
  input  wire logic [4:0]  pin_wake_evt
);
  logic        rd_fault;
  logic        rd_wake;
  logic        txd_to_reg;
  logic        txd_to_next;
  logic        bus_to_reg;
  logic        bus_to_next;
  logic        uv_reg;
  logic        uv_next;
  logic        sys_err_reg;
  logic        sys_err_next;
  logic        hold_reg;
  logic        hold_next;
  logic        interrupt_out_n_prev_reg;
  logic        interrupt_out_n_fall;
  logic        sil_prev_reg;
  logic        bus_timeout_flag;
  logic [1:0]  fault_code;
  logic [15:0] wake_flags;
  logic [15:0] fault_word;
  logic [15:0] wake_set;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        uv_detect_en;
  logic        timeout_set;

  assign rd_fault     = reg_rd && (reg_addr == bws_pkg::BWS_OFS_FAULT);
  assign rd_wake      = reg_rd && (reg_addr == bws_pkg::BWS_OFS_WAKE);
  assign uv_detect_en = xcvr_normal || xcvr_rx_only;
  assign interrupt_out_n_fall    = interrupt_out_n_prev_reg && !interrupt_out_n;
  // Silence rising edge sets; the flag outlives the indication
  assign timeout_set  = selective_wake_enable && bus_silence_indication
                        && !sil_prev_reg;

  // Fault condition flags: live conditions with defined recovery
  always_comb
  begin
    txd_to_next = txd_to_reg;
    bus_to_next = bus_to_reg;
    uv_next     = uv_reg;
    if (txd_dom_detect)
      txd_to_next = 1'b1;
    else if (txd_high || xcvr_wake_capable || xcvr_off)
      txd_to_next = 1'b0;
    if (bus_dom_detect)
      bus_to_next = 1'b1;
    else if (bus_recessive || xcvr_wake_capable || xcvr_off)
      bus_to_next = 1'b0;
    if (uv_detect_en && supply_below_thr)
      uv_next = 1'b1;
    else if (!supply_below_thr)
      uv_next = 1'b0;
  end

  // System error: only follows its causes with selective wake on
  always_comb
  begin
    sys_err_next = sys_err_reg;
    if (selective_wake_enable)
      sys_err_next = config_error || (error_count > bws_pkg::BWS_ERR_LIMIT);
  end

  // Clear protection for the timeout flag until the next interrupt falling edge
  always_comb
  begin
    hold_next = hold_reg;
    if (timeout_set)
      hold_next = 1'b1;
    else if (interrupt_out_n_fall)
      hold_next = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      txd_to_reg    <= 1'b0;
      bus_to_reg    <= 1'b0;
      uv_reg        <= 1'b0;
      sys_err_reg   <= 1'b0;
      hold_reg      <= 1'b0;
      interrupt_out_n_prev_reg <= 1'b1;
      sil_prev_reg  <= 1'b0;
    end
    else
    begin
      txd_to_reg    <= txd_to_next;
      bus_to_reg    <= bus_to_next;
      uv_reg        <= uv_next;
      sys_err_reg   <= sys_err_next;
      hold_reg      <= hold_next;
      interrupt_out_n_prev_reg <= interrupt_out_n;
      sil_prev_reg  <= bus_silence_indication;
    end
  end

  // Priority: thermal, then bus dominant, then TXD dominant
  always_comb
  begin
    if (thermal_shutdown)
      fault_code = bws_pkg::BWS_CODE_THERMAL;
    else if (bus_to_reg)
      fault_code = bws_pkg::BWS_CODE_BUS_DOM;
    else if (txd_to_reg)
      fault_code = bws_pkg::BWS_CODE_TXD_DOM;
    else
      fault_code = bws_pkg::BWS_CODE_NONE;
  end

  // Timeout flag: a read is ignored while protected; restart keeps it
  bws_sticky_bit u_timeout
  (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .set_evt     (timeout_set),
    .clr_evt     (rd_fault && !hold_reg),
    .restart_clr (1'b0),
    .flag        (bus_timeout_flag)
  );

  assign bus_timeout_irq = bus_timeout_flag && bus_timeout_irq_mask
                           && mode_stop_or_normal;

  bws_tx_recover u_txrec
  (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .fault_active (uv_reg || txd_to_reg || bus_to_reg || thermal_shutdown),
    .txd_high     (txd_high),
    .tx_enable    (tx_enable)
  );

  // Wake events placed at their register bit positions
  always_comb
  begin
    wake_set = '0;
    wake_set[bws_pkg::BWS_POS_BUS_WAKE]         = bus_wake_evt;
    wake_set[bws_pkg::BWS_POS_TIMER2]           = timer2_wake_evt;
    wake_set[bws_pkg::BWS_POS_TIMER1]           = timer1_wake_evt;
    wake_set[bws_pkg::BWS_NUM_PINS-1:0]         = pin_wake_evt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_wake
      if (bws_pkg::BWS_WAKE_IMPL[gi])
      begin : g_impl
        bws_sticky_bit u_bit
        (
          .core_clk    (core_clk),
          .sys_rst     (sys_rst),
          .set_evt     (wake_set[gi]),
          .clr_evt     (rd_wake || failsafe_entry),
          .restart_clr (restart_evt && !bws_pkg::BWS_WAKE_KEEP[gi]),
          .flag        (wake_flags[gi])
        );
      end
      else
      begin : g_res
        assign wake_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // Fault word; the rc bits other than the timeout are live conditions
  always_comb
  begin
    fault_word = '0;
    fault_word[bws_pkg::BWS_POS_TIMEOUT]                           = bus_timeout_flag;
    fault_word[bws_pkg::BWS_POS_SELECTIVE_WAKE_SYS_ERROR]                            = sys_err_reg;
    fault_word[bws_pkg::BWS_POS_CODE_LO+1:bws_pkg::BWS_POS_CODE_LO] = fault_code;
    fault_word[bws_pkg::BWS_POS_UNDERVOLT]                         = uv_reg;
    fault_word = fault_word & bws_pkg::BWS_FAULT_IMPL & bws_pkg::BWS_FAULT_KEEP;
  end

  // Read data registered; captured value is pre-clear
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_fault)
      rdata_next = fault_word;
    else if (rd_wake)
      rdata_next = wake_flags & bws_pkg::BWS_WAKE_IMPL;
    else if (reg_rd)
      rdata_next = bws_pkg::BWS_RESET_VALUE;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rdata_reg <= bws_pkg::BWS_RESET_VALUE;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;
endmodule : bws_status_flags

// [design/bws_pkg.sv]
// Package: offsets, field positions, reset values and timing for the status flag bank
package bws_pkg;
  localparam logic [6:0]  BWS_OFS_FAULT      = 7'h43;
  localparam logic [6:0]  BWS_OFS_WAKE       = 7'h44;
  localparam logic [15:0] BWS_RESET_VALUE    = 16'h0000;
  // Fault register fields
  localparam int          BWS_POS_UNDERVOLT  = 0;
  localparam int          BWS_POS_CODE_LO    = 1;
  localparam int          BWS_POS_SELECTIVE_WAKE_SYS_ERROR     = 3;
  localparam int          BWS_POS_TIMEOUT    = 4;
  // Bits kept over a restart
  localparam logic [15:0] BWS_FAULT_KEEP     = 16'h007F;
  localparam logic [15:0] BWS_WAKE_KEEP      = 16'h0782;
  // Implemented (non-reserved) bits
  localparam logic [15:0] BWS_FAULT_IMPL     = 16'h001F;
  localparam logic [15:0] BWS_WAKE_IMPL      = 16'h039F;
  localparam int          BWS_POS_BUS_WAKE   = 9;
  localparam int          BWS_POS_TIMER2     = 8;
  localparam int          BWS_POS_TIMER1     = 7;
  localparam int          BWS_NUM_PINS       = 5;
  // Fault codes
  localparam logic [1:0]  BWS_CODE_NONE      = 2'h0;
  localparam logic [1:0]  BWS_CODE_THERMAL   = 2'h1;
  localparam logic [1:0]  BWS_CODE_TXD_DOM   = 2'h2;
  localparam logic [1:0]  BWS_CODE_BUS_DOM   = 2'h3;
  // Error counter overflow limit
  localparam logic [5:0]  BWS_ERR_LIMIT      = 6'h20;
  // Transmitter enable time, nanoseconds, and cycles at 4 ns
  localparam int          BWS_CLK_NS         = 4;
  localparam int          BWS_TX_EN_NS       = 4000;
  localparam int          BWS_TX_EN_CYC      = (BWS_TX_EN_NS + BWS_CLK_NS - 1) / BWS_CLK_NS;
  localparam logic [9:0]  BWS_TX_EN_CNT      = 10'(BWS_TX_EN_CYC);
endpackage : bws_pkg

// [design/bws_sticky_bit.sv]
// One sticky status flag: set wins over clear, restart may keep or clear it
module bws_sticky_bit
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic set_evt,
  input  wire logic clr_evt,
  input  wire logic restart_clr,
  // State
  output logic      flag
);
  logic flag_reg;
  logic flag_next;

  always_comb
  begin
    flag_next = flag_reg;
    if (clr_evt || restart_clr)
    begin
      flag_next = 1'b0;
    end
    if (set_evt)
    begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;
endmodule : bws_sticky_bit

// [design/bws_tx_recover.sv]
// Transmit re-enable timer: counts cycles of recessive transmit data after a fault
module bws_tx_recover
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Inputs
  input  wire logic fault_active,
  input  wire logic txd_high,
  // Result
  output logic      tx_enable
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic       blk_reg;
  logic       blk_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    blk_next = blk_reg;
    if (fault_active)
    begin
      blk_next = 1'b1;
      cnt_next = '0;
    end
    else if (blk_reg)
    begin
      if (!txd_high)
        cnt_next = '0;
      else if (cnt_reg == bws_pkg::BWS_TX_EN_CNT - 10'h001)
        blk_next = 1'b0;
      else
        cnt_next = cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= '0;
      blk_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      blk_reg <= blk_next;
    end
  end

  assign tx_enable = !blk_reg && !fault_active;
endmodule : bws_tx_recover

// [testbench/bws_status_flags_asserts.sv]
// Checker: port relations of the status flag bank
module bws_status_flags_asserts
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Read port
  input wire logic        reg_rd,
  input wire logic [6:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  // Transceiver
  input wire logic        txd_high,
  input wire logic        thermal_shutdown,
  input wire logic        supply_below_thr,
  input wire logic        xcvr_normal,
  input wire logic        tx_enable,
  // Timeout interrupt
  input wire logic        mode_stop_or_normal,
  input wire logic        bus_timeout_irq_mask,
  input wire logic        bus_timeout_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Three cycles lets a registered detector settle
  sequence s_uv_held;
    (supply_below_thr && xcvr_normal)[*3];
  endsequence
  sequence s_rd(logic [6:0] a);
    reg_rd && reg_addr == a;
  endsequence
  a_fault_rsv_zero: assert property (s_rd(7'h43) |=> reg_rdata[15:5] == 11'h000)
    else $error("fault register reserved bits set");
  a_wake_rsv_zero: assert property (s_rd(7'h44) |=> (reg_rdata & 16'hFC60) == 16'h0000)
    else $error("wake register reserved bits set");
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 16'h0000)
    else $error("read data not zero after reset");
  a_uv_bit_set: assert property (s_uv_held ##0 s_rd(7'h43) |=> reg_rdata[0])
    else $error("undervoltage bit not reported");
  a_uv_tx_off: assert property (s_uv_held |-> !tx_enable)
    else $error("transmitter on during undervoltage");
  a_thermal_tx_off: assert property (thermal_shutdown[*2] |-> !tx_enable)
    else $error("transmitter on during thermal shutdown");
  a_tx_reenable: assert property ($rose(tx_enable) |-> $past(txd_high))
    else $error("transmitter enabled without recessive data");
  a_irq_gated: assert property (bus_timeout_irq |-> bus_timeout_irq_mask && mode_stop_or_normal)
    else $error("timeout interrupt outside mask or mode");
endmodule : bws_status_flags_asserts

// [testbench/bws_host_model.sv]
// Host model: register reads and the transmit data level
module bws_host_model
(
  // Clock
  input  wire logic        core_clk,
  // Read port
  input  wire logic [15:0] reg_rdata,
  output logic             reg_rd,
  output logic [6:0]       reg_addr,
  // Transmit data
  output logic             txd_high
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_rd   = 1'b0;
    reg_addr = 7'h00;
    txd_high = 1'b1; // Recessive unless a scenario pulls it
  end
  // Call just after a rising edge; the address is flipped on release
  task automatic read_word(input logic [6:0] a, output logic [15:0] d);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    // Idle edge between reads so the strobe is never re-raised in one step
    @(posedge core_clk);
    #1;
  endtask : read_word
endmodule : bws_host_model

// [testbench/test_bws_status_flags.sv]
// Testbench for the bus and wake status flag bank
module test_bws_status_flags;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, sys_rst, restart_evt, failsafe_entry, reg_rd, tx_enable, txd_high;
  logic        xcvr_normal, xcvr_rx_only, xcvr_wake_capable, xcvr_off, bus_recessive;
  logic        thermal_shutdown, txd_dom_detect, bus_dom_detect, supply_below_thr;
  logic        selective_wake_enable, bus_silence_indication, config_error, interrupt_out_n;
  logic        mode_stop_or_normal, bus_timeout_irq_mask, bus_timeout_irq;
  logic        bus_wake_evt, timer1_wake_evt, timer2_wake_evt;
  logic [4:0]  pin_wake_evt;
  logic [5:0]  error_count;
  logic [6:0]  reg_addr;
  logic [15:0] reg_rdata, v;
  int          miscompares, compares, n;
  bws_status_flags uut (.*);
  bws_host_model host (.*);
  always #2 core_clk = ~core_clk;
  task automatic tk(input int k = 1);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tk
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [15:0] m, input logic [15:0] exp);
    host.read_word(a, v);
    chk(v & m, exp);
  endtask : rd
  task automatic wake_all();
    {bus_wake_evt, timer2_wake_evt, timer1_wake_evt, pin_wake_evt} = 8'hFF;
    tk();
    {bus_wake_evt, timer2_wake_evt, timer1_wake_evt, pin_wake_evt} = 8'h00;
    tk(3);
  endtask : wake_all
  task automatic finish_test();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial
  begin
    {core_clk, restart_evt, failsafe_entry, xcvr_rx_only, xcvr_wake_capable, xcvr_off} = '0;
    {thermal_shutdown, txd_dom_detect, bus_dom_detect, supply_below_thr, error_count} = '0;
    {selective_wake_enable, bus_silence_indication, config_error, pin_wake_evt} = '0;
    {bus_wake_evt, timer1_wake_evt, timer2_wake_evt, miscompares, compares} = '0;
    {sys_rst, xcvr_normal, bus_recessive, mode_stop_or_normal} = '1;
    {bus_timeout_irq_mask, interrupt_out_n} = '1;
    tk(16);
    sys_rst = 1'b0;
    rd(7'h43, 16'hFFFF, 16'h0000);
    rd(7'h44, 16'hFFFF, 16'h0000);
    wake_all();
    rd(7'h44, 16'hFFFF, 16'h039F);
    rd(7'h44, 16'hFFFF, 16'h0000);
    wake_all();
    restart_evt = 1'b1;
    tk();
    restart_evt = 1'b0;
    rd(7'h44, 16'hFFFF, 16'h0382);
    wake_all();
    failsafe_entry = 1'b1;
    tk();
    failsafe_entry = 1'b0;
    rd(7'h44, 16'hFFFF, 16'h0000);
    wake_all();
    sys_rst = 1'b1;
    tk(2);
    sys_rst = 1'b0;
    rd(7'h44, 16'hFFFF, 16'h0000);
    bus_wake_evt = 1'b1;
    host.read_word(7'h44, v);
    bus_wake_evt = 1'b0;
    rd(7'h44, 16'hFFFF, 16'h0200);
    $display("Test wake flags done");
    host.txd_high = 1'b0;
    txd_dom_detect = 1'b1;
    tk();
    txd_dom_detect = 1'b0;
    tk(2);
    rd(7'h43, 16'h0006, 16'h0004);
    host.txd_high = 1'b1;
    tk(2);
    rd(7'h43, 16'h0006, 16'h0000);
    bus_recessive = 1'b0;
    bus_dom_detect = 1'b1;
    tk();
    bus_dom_detect = 1'b0;
    tk(2);
    rd(7'h43, 16'h0006, 16'h0006);
    bus_recessive = 1'b1;
    tk(2);
    rd(7'h43, 16'h0006, 16'h0000);
    thermal_shutdown = 1'b1;
    tk(2);
    rd(7'h43, 16'h0006, 16'h0002);
    restart_evt = 1'b1;
    tk();
    restart_evt = 1'b0;
    rd(7'h43, 16'hFFFF, 16'h0002);
    thermal_shutdown = 1'b0;
    tk(900);
    chk(16'(tx_enable), 16'h0000);
    for (n = 0; n < 200 && tx_enable !== 1'b1; n++)
      tk();
    chk(16'(tx_enable), 16'h0001);
    if (n == 200)
      finish_test();
    $display("Test fault codes done");
    supply_below_thr = 1'b1;
    tk(3);
    rd(7'h43, 16'h0001, 16'h0001);
    chk(16'(tx_enable), 16'h0000);
    supply_below_thr = 1'b0;
    tk(2);
    rd(7'h43, 16'h0001, 16'h0000);
    xcvr_normal = 1'b0;
    supply_below_thr = 1'b1;
    tk(3);
    rd(7'h43, 16'h0001, 16'h0000);
    {xcvr_normal, supply_below_thr} = 2'h2;
    selective_wake_enable = 1'b1;
    config_error = 1'b1;
    tk(2);
    rd(7'h43, 16'h0008, 16'h0008);
    {selective_wake_enable, config_error} = 2'h0;
    tk(2);
    rd(7'h43, 16'h0008, 16'h0008);
    selective_wake_enable = 1'b1;
    error_count = 6'h20;
    tk(2);
    rd(7'h43, 16'h0008, 16'h0000);
    error_count = 6'h21;
    tk(2);
    rd(7'h43, 16'h0008, 16'h0008);
    error_count = 6'h00;
    $display("Test supply and system error done");
    selective_wake_enable = 1'b0;
    bus_silence_indication = 1'b1;
    tk(2);
    rd(7'h43, 16'h0010, 16'h0000);
    bus_silence_indication = 1'b0;
    selective_wake_enable = 1'b1;
    tk();
    bus_silence_indication = 1'b1;
    tk(2);
    chk(16'(bus_timeout_irq), 16'h0001);
    rd(7'h43, 16'h0010, 16'h0010);
    bus_silence_indication = 1'b0;
    bus_timeout_irq_mask = 1'b0;
    tk();
    chk(16'(bus_timeout_irq), 16'h0000);
    rd(7'h43, 16'h0010, 16'h0010);
    interrupt_out_n = 1'b0;
    tk(2);
    interrupt_out_n = 1'b1;
    rd(7'h43, 16'h0010, 16'h0010);
    rd(7'h43, 16'h0010, 16'h0000);
    $display("Test bus timeout done");
    finish_test();
  end
endmodule : test_bws_status_flags
bind bws_status_flags bws_status_flags_asserts chk (.*);
